// [hw/line_cfg_regs.svh]
// Offsets, field positions, reset values and FIFO sizes of the line configuration block
`ifndef LINE_CFG_REGS_SVH
`define LINE_CFG_REGS_SVH
`define RATE_CTRL_ADDR        3'h4
`define RATE_CTRL_WIDTH       5
`define RATE_CTRL_RESET       5'h00
`define RATE_CTRL_SONET_BIT   3
`define RATE_CTRL_EURO_BIT    2
`define RATE_CTRL_LLB_BIT     1
`define RATE_CTRL_RLB_BIT     0
`define MGMT_ADDR_WIDTH       3
`define TX_FIFO_DEPTH         8
`define TX_FIFO_WIDTH         2
`endif

// [hw/line_cfg_pkg.sv]
// Types shared by the line configuration block
package line_cfg_pkg;
  typedef enum logic [1:0] {
    RATE_DS3   = 2'b00,
    RATE_STS1  = 2'b01,
    RATE_E3    = 2'b10
  } line_rate_e;

  typedef enum logic [1:0] {
    CODE_B3ZS   = 2'b00,
    CODE_HDB3   = 2'b01,
    CODE_BYPASS = 2'b10
  } line_code_e;

  // Settings derived from the rate that steer the analogue and receive sections
  typedef struct packed {
    line_rate_e rate;
    line_code_e code;
    logic [1:0] vco_centre_sel;
    logic [1:0] pulse_shape_sel;
    logic [1:0] los_criteria_sel;
  } rate_cfg_s;

  // One sampled bit pair from the framer
  typedef struct packed {
    logic pos;
    logic neg;
  } rail_pair_s;

  // Pulse request toward the line driver
  typedef struct packed {
    logic pulse_pos;
    logic pulse_neg;
  } line_pulse_s;
endpackage : line_cfg_pkg

// [hw/rail_fifo.sv]
// Small flip-flop FIFO buffering sampled rail pairs on a single clock
`timescale 1ns/100ps
module rail_fifo #(
  parameter int WIDTH = 2,
  parameter int DEPTH = 8
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             arst_n,
  // Fill side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);
  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0]               wr_ptr;
    logic [AW-1:0]               rd_ptr;
    logic [AW:0]                 count;
  } fifo_state_s;

  fifo_state_s state_reg;
  fifo_state_s state_next;
  logic        push;
  logic        pop;

  initial
  begin
    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0 || WIDTH < 1)
      $error("rail_fifo: DEPTH must be a power of two of at least 2");
  end

  assign in_ready  = (state_reg.count != (AW+1)'(DEPTH));
  assign out_valid = (state_reg.count != '0);
  assign out_data  = state_reg.mem[state_reg.rd_ptr];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  // Pointer and occupancy update
  always_comb
  begin
    state_next = state_reg;
    if (push)
    begin
      state_next.mem[state_reg.wr_ptr] = in_data;
      state_next.wr_ptr = state_reg.wr_ptr + AW'(1);
    end
    if (pop)
      state_next.rd_ptr = state_reg.rd_ptr + AW'(1);
    case ({push, pop})
      2'b10:   state_next.count = state_reg.count + (AW+1)'(1);
      2'b01:   state_next.count = state_reg.count - (AW+1)'(1);
      default: state_next.count = state_reg.count;
    endcase
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      state_reg <= '0;
    else
      state_reg <= state_next;
  end
endmodule : rail_fifo

// [hw/tx_rail_input_and_rate_config.sv]
// Configuration selection, rate decode and transmit rail capture of the line interface
// Behaviour
// - Strap low: serial management off, configuration taken from dedicated pins.
// - Pin mode: serial pins take alternate roles (format, coder, mute, flag, clock).
// - Strap high: serial management on, configuration taken from command register.
// - Register mode: amplitude, all-ones, equaliser, loopbacks, rate, E3, tx-off pins ignored.
// - Pin mode: E3 pin high gives E3; else rate pin picks DS3 or STS-1.
// - Register mode: bit 2 selects E3; else bit 3 picks DS3 or STS-1.
// - Clock-recovery centre frequency follows the selected rate.
// - HDB3 coding for E3, B3ZS for DS3 and STS-1.
// - Pulse shape, width and loss-of-signal criteria follow the selected rate.
// - Dual-rail inputs captured on the falling edge of the transmit clock.
// - A one on the positive rail yields a positive line pulse.
// - A one on the negative rail yields a negative line pulse.
// - Mark is one pulse of either polarity; space is no pulse.
// - Binary-input bit set: single rail on positive input, negative ignored, coder on.
// - Coder disabled: rails pass to the line as received, except a pair with both rails high goes out as a space.
`timescale 1ns/100ps
`include "line_cfg_regs.svh"
module tx_rail_input_and_rate_config
  import line_cfg_pkg::*;
#(
  parameter int FIFO_DEPTH = `TX_FIFO_DEPTH
) (
  // System clock and reset
  input  wire logic       clk,
  input  wire logic       arst_n,
  // Configuration source
  input  wire logic       config_source_strap,
  // Dedicated configuration pins, live in pin mode only
  input  wire logic       tx_amplitude_level,
  input  wire logic       tx_all_ones_send,
  input  wire logic       rx_equaliser_disable,
  input  wire logic       local_loopback,
  input  wire logic       remote_loopback,
  input  wire logic       sonet_rate_select,
  input  wire logic       euro_rate_select,
  input  wire logic       transmitter_off,
  // Dual-role serial pins, register-port view
  input  wire logic       mgmt_chip_select_n,
  input  wire logic       mgmt_serial_clock,
  input  wire logic       serial_mgmt_in,
  input  wire logic       register_clear_n,
  output logic            serial_mgmt_out,
  output logic            serial_mgmt_out_oe,
  // Command register port from the serial engine (system clock)
  input  wire logic       reg_wr_en,
  input  wire logic [2:0] reg_addr,
  input  wire logic [4:0] reg_wr_data,
  output logic [4:0]      reg_rd_data,
  input  wire logic       tx_binary_input_select,
  input  wire logic       coder_disable_bit,
  // Receive-side status feeding dual-role outputs
  input  wire logic       rx_violation,
  input  wire logic       first_rx_clock,
  // Transmit link from the framer
  input  wire logic       tx_line_clock,
  input  wire logic       tx_positive_rail,
  input  wire logic       tx_negative_rail,
  // Line pulse requests toward the driver
  output line_pulse_s     line_pulse,
  output logic            line_pulse_valid,
  // Derived configuration
  output rate_cfg_s       rate_cfg,
  output logic            mgmt_enabled,
  output logic            rail_single_mode,
  output logic            coder_bypass,
  output logic            signal_loss_mute_enable,
  output logic            second_rx_clock_invert,
  output logic            line_violation_flag,
  output logic            second_rx_clock,
  output logic            tx_amp_level_eff,
  output logic            tx_all_ones_eff,
  output logic            rx_eq_disable_eff,
  output logic            local_loop_eff,
  output logic            remote_loop_eff,
  output logic            tx_off_eff
);
  initial
  begin
    if (FIFO_DEPTH < 2)
      $error("tx_rail_input_and_rate_config: FIFO_DEPTH must be at least 2");
  end

  // System-domain state
  typedef struct packed {
    logic [2:0] strap_sync;
    logic [2:0] sonet_sync;
    logic [2:0] euro_sync;
    logic [2:0] fmt_sync;
    logic [2:0] cdis_sync;
    logic [2:0] tog_sync;
    logic       tog_seen;
    logic [1:0] fill;
    logic       strap;
    logic       sonet;
    logic       euro;
    logic       fmt;
    logic       cdis;
    logic       started;
    logic [4:0] rate_ctrl;
    rate_cfg_s  cfg;
    line_pulse_s pulse;
    logic       pulse_valid;
  } sys_state_s;

  // Link-domain state, clocked on the falling transmit-clock edge
  typedef struct packed {
    rail_pair_s sample;
    logic       tog;
  } link_state_s;

  sys_state_s  sys_reg;
  sys_state_s  sys_next;
  link_state_s link_reg;
  link_state_s link_next;
  logic        link_rst_n_meta;
  logic        link_rst_n;
  logic        bit_arrived;
  logic        fifo_in_ready;
  logic        fifo_out_valid;
  logic [1:0]  fifo_out_data;
  logic        fifo_out_ready;
  rail_pair_s  drained;
  logic        single_rail;
  line_rate_e  rate_now;

  // Reset release for the link domain, also on the falling edge
  always_ff @(negedge tx_line_clock or negedge arst_n)
  begin
    if (!arst_n)
    begin
      link_rst_n_meta <= 1'b0;
      link_rst_n      <= 1'b0;
    end
    else
    begin
      link_rst_n_meta <= 1'b1;
      link_rst_n      <= link_rst_n_meta;
    end
  end

  // Capture both rails each falling edge; single rail drops the negative input
  always_comb
  begin
    link_next              = link_reg;
    link_next.sample.pos   = tx_positive_rail;
    link_next.sample.neg   = single_rail ? 1'b0 : tx_negative_rail;
    link_next.tog          = !link_reg.tog; // Flips once per captured bit
  end

  always_ff @(negedge tx_line_clock or negedge link_rst_n)
  begin
    if (!link_rst_n)
      link_reg <= '0;
    else
      link_reg <= link_next;
  end

  // Single-rail select is quasi-static; it only changes with the transmit path idle
  assign single_rail = rail_single_mode;

  // A captured bit is announced by the toggle; the sample holds for a whole link period,
  // so it is settled when the synchronised toggle is seen. Link clock must stay below
  // roughly a quarter of the system clock for this to hold.
  assign bit_arrived = (sys_reg.tog_sync[2] == sys_reg.tog_sync[1])
                       && (sys_reg.tog_sync[2] != sys_reg.tog_seen);

  // FIFO on the system clock buffers bits between the crossing and the pulse stage
  rail_fifo #(
    .WIDTH (`TX_FIFO_WIDTH),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk       (clk),
    .arst_n    (arst_n),
    .in_valid  (bit_arrived),
    .in_ready  (fifo_in_ready),
    .in_data   (link_reg.sample),
    .out_valid (fifo_out_valid),
    .out_ready (fifo_out_ready),
    .out_data  (fifo_out_data)
  );
  assign fifo_out_ready = 1'b1;
  assign drained        = rail_pair_s'(fifo_out_data);

  // Rate decode from whichever source the strap selects
  always_comb
  begin
    if (sys_reg.strap)
    begin
      if (sys_reg.rate_ctrl[`RATE_CTRL_EURO_BIT])
        rate_now = RATE_E3;
      else if (sys_reg.rate_ctrl[`RATE_CTRL_SONET_BIT])
        rate_now = RATE_STS1;
      else
        rate_now = RATE_DS3;
    end
    else
    begin
      if (sys_reg.euro)
        rate_now = RATE_E3;
      else if (sys_reg.sonet)
        rate_now = RATE_STS1;
      else
        rate_now = RATE_DS3;
    end
  end

  // Synchronisers, configuration registers and pulse mapping
  always_comb
  begin
    sys_next = sys_reg;
    sys_next.strap_sync = {sys_reg.strap_sync[1:0], config_source_strap};
    sys_next.sonet_sync = {sys_reg.sonet_sync[1:0], sonet_rate_select};
    sys_next.euro_sync  = {sys_reg.euro_sync[1:0], euro_rate_select};
    sys_next.fmt_sync   = {sys_reg.fmt_sync[1:0], mgmt_chip_select_n};
    sys_next.cdis_sync  = {sys_reg.cdis_sync[1:0], mgmt_serial_clock};
    sys_next.tog_sync   = {sys_reg.tog_sync[1:0], link_reg.tog};
    if (bit_arrived)
      sys_next.tog_seen = sys_reg.tog_sync[2];
    // Wait until the synchroniser holds real pin samples, not reset values
    if (sys_reg.fill != 2'h3)
      sys_next.fill = sys_reg.fill + 2'h1;
    // Strap taken once after reset release and then held
    if (!sys_reg.started && (sys_reg.fill == 2'h3)
        && (sys_reg.strap_sync[2] == sys_reg.strap_sync[1]))
    begin
      sys_next.strap   = sys_reg.strap_sync[2];
      sys_next.started = 1'b1;
    end
    // Rate pins followed continuously
    if (sys_reg.sonet_sync[2] == sys_reg.sonet_sync[1])
      sys_next.sonet = sys_reg.sonet_sync[2];
    if (sys_reg.euro_sync[2] == sys_reg.euro_sync[1])
      sys_next.euro = sys_reg.euro_sync[2];
    if (sys_reg.fmt_sync[2] == sys_reg.fmt_sync[1])
      sys_next.fmt = sys_reg.fmt_sync[2];
    if (sys_reg.cdis_sync[2] == sys_reg.cdis_sync[1])
      sys_next.cdis = sys_reg.cdis_sync[2];
    // Command register written only while the serial interface is live
    if (sys_reg.strap && !register_clear_n)
      sys_next.rate_ctrl = `RATE_CTRL_RESET;
    else if (sys_reg.strap && reg_wr_en && reg_addr == `RATE_CTRL_ADDR)
      sys_next.rate_ctrl = reg_wr_data;
    // Rate-derived settings
    sys_next.cfg.rate             = rate_now;
    sys_next.cfg.vco_centre_sel   = rate_now;
    sys_next.cfg.pulse_shape_sel  = rate_now;
    sys_next.cfg.los_criteria_sel = rate_now;
    if (coder_bypass)
      sys_next.cfg.code = CODE_BYPASS;
    else if (rate_now == RATE_E3)
      sys_next.cfg.code = CODE_HDB3;
    else
      sys_next.cfg.code = CODE_B3ZS;
    // Each drained bit maps to at most one pulse; both rails high counts as a space
    sys_next.pulse_valid = fifo_out_valid;
    if (fifo_out_valid)
    begin
      sys_next.pulse.pulse_pos = drained.pos && !drained.neg;
      sys_next.pulse.pulse_neg = drained.neg && !drained.pos;
    end
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      sys_reg <= '0;
    else
      sys_reg <= sys_next;
  end

  // Pin or register source for the live configuration
  assign mgmt_enabled = sys_reg.strap;
  // Single rail needs the coder, so it overrides any bypass request
  assign coder_bypass = (sys_reg.strap ? coder_disable_bit : sys_reg.cdis)
                        && !rail_single_mode;
  assign rail_single_mode = sys_reg.strap ? tx_binary_input_select : sys_reg.fmt;
  assign signal_loss_mute_enable = !sys_reg.strap && serial_mgmt_in;
  assign second_rx_clock_invert  = !sys_reg.strap && !register_clear_n;
  assign line_violation_flag = !sys_reg.strap && rx_violation;
  assign second_rx_clock = !sys_reg.strap && (first_rx_clock ^ second_rx_clock_invert);
  assign serial_mgmt_out     = rx_violation;
  assign serial_mgmt_out_oe  = !sys_reg.strap;
  assign reg_rd_data = (sys_reg.strap && reg_addr == `RATE_CTRL_ADDR)
                       ? sys_reg.rate_ctrl : 5'h00;

  // Pins disregarded while the register source is in force
  assign tx_amp_level_eff  = !sys_reg.strap && tx_amplitude_level;
  assign tx_all_ones_eff   = !sys_reg.strap && tx_all_ones_send;
  assign rx_eq_disable_eff = !sys_reg.strap && rx_equaliser_disable;
  assign local_loop_eff    = sys_reg.strap ? sys_reg.rate_ctrl[`RATE_CTRL_LLB_BIT]
                                           : local_loopback;
  assign remote_loop_eff   = sys_reg.strap ? sys_reg.rate_ctrl[`RATE_CTRL_RLB_BIT]
                                           : remote_loopback;
  assign tx_off_eff        = !sys_reg.strap && transmitter_off;

  assign rate_cfg         = sys_reg.cfg;
  assign line_pulse       = sys_reg.pulse;
  assign line_pulse_valid = sys_reg.pulse_valid;
endmodule : tx_rail_input_and_rate_config

// [testbench/tx_rate_checker.sv]
// Port-level assertions for the transmit rail and rate configuration block
`timescale 1ns/100ps
module tx_rate_checker
  import line_cfg_pkg::*;
(
  // Clock and reset
  input wire logic        clk,
  input wire logic        arst_n,
  // Configuration inputs
  input wire logic        euro_rate_select,
  input wire logic        reg_wr_en,
  input wire logic [2:0]  reg_addr,
  input wire logic [4:0]  reg_wr_data,
  // Observed outputs
  input wire logic        mgmt_enabled,
  input wire logic        serial_mgmt_out_oe,
  input wire logic        line_violation_flag,
  input wire logic        second_rx_clock,
  input wire logic        rail_single_mode,
  input wire logic        coder_bypass,
  input wire line_pulse_s line_pulse,
  input wire logic        line_pulse_valid,
  input wire rate_cfg_s   rate_cfg
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);

  // Rate selection and the settings derived from it
  chk_pin_euro_rate: assert property ((!mgmt_enabled && euro_rate_select) [*8]
    |-> rate_cfg.rate == RATE_E3) else $error("E3 pin ignored");
  chk_reg_euro_write: assert property (mgmt_enabled && reg_wr_en && reg_addr == 3'h4
    && reg_wr_data[2] |-> ##[1:4] rate_cfg.rate == RATE_E3) else $error("E3 bit ignored");
  chk_vco_follows_rate: assert property (rate_cfg.vco_centre_sel == rate_cfg.rate)
    else $error("VCO select off rate");
  chk_code_by_rate: assert property (rate_cfg.code != CODE_BYPASS
    |-> (rate_cfg.code == CODE_HDB3) == (rate_cfg.rate == RATE_E3)) else $error("Bad code");
  chk_shape_los_rate: assert property (rate_cfg.pulse_shape_sel == rate_cfg.rate
    && rate_cfg.los_criteria_sel == rate_cfg.rate) else $error("Shape or LOS select off rate");
  // Coder control
  chk_bypass_code: assert property (coder_bypass [*3] |-> rate_cfg.code == CODE_BYPASS)
    else $error("Bypass not applied");
  chk_single_coder_on: assert property (rail_single_mode [*3] |-> rate_cfg.code != CODE_BYPASS)
    else $error("Coder off in single rail");
  // Dual-role pins
  chk_alt_pin_drive: assert property (serial_mgmt_out_oe == !mgmt_enabled)
    else $error("Flag pin enable wrong");
  chk_reg_alt_quiet: assert property (mgmt_enabled |-> !line_violation_flag && !second_rx_clock)
    else $error("Alternate outputs active in register mode");
  // A bit is one pulse of one polarity or none
  chk_pulse_polarity: assert property (line_pulse_valid
    |-> !(line_pulse.pulse_pos && line_pulse.pulse_neg)) else $error("Both pulses");

  cover property (line_pulse_valid && line_pulse.pulse_neg);
  cover property (mgmt_enabled && rate_cfg.rate == RATE_STS1);
  cover property (coder_bypass && line_pulse_valid);
endmodule : tx_rate_checker

bind tx_rail_input_and_rate_config tx_rate_checker checker_i (
  .clk(clk), .arst_n(arst_n), .euro_rate_select(euro_rate_select), .reg_wr_en(reg_wr_en),
  .reg_addr(reg_addr), .reg_wr_data(reg_wr_data), .mgmt_enabled(mgmt_enabled),
  .serial_mgmt_out_oe(serial_mgmt_out_oe), .line_violation_flag(line_violation_flag),
  .second_rx_clock(second_rx_clock), .rail_single_mode(rail_single_mode),
  .coder_bypass(coder_bypass), .line_pulse(line_pulse), .line_pulse_valid(line_pulse_valid),
  .rate_cfg(rate_cfg)
);

// [testbench/framer_model.sv]
// Behavioural framer driving the transmit rails and link clock
`timescale 1ns/100ps
module framer_model (
  // Link outputs
  output logic tx_line_clock,
  output logic tx_positive_rail,
  output logic tx_negative_rail
);
  // Clock idles low between frames
  initial
  begin
    tx_line_clock    = 1'b0;
    tx_positive_rail = 1'b0;
    tx_negative_rail = 1'b0;
  end

  // LSB first; three spaces each side absorb link reset release and flush the FIFO
  task automatic send(input logic [15:0] pos, input logic [15:0] neg, input int len);
    int i;
    for (i = -3; i < len + 3; i++)
    begin
      tx_line_clock = 1'b1;
      #1;
      tx_positive_rail = (i >= 0 && i < len) ? pos[i] : 1'b0;
      tx_negative_rail = (i >= 0 && i < len) ? neg[i] : 1'b0;
      #31 tx_line_clock = 1'b0;
      #32;
    end
    // Stale data must not look valid once the frame is over
    tx_positive_rail = ~tx_positive_rail;
    tx_negative_rail = ~tx_negative_rail;
  endtask : send
endmodule : framer_model

// [testbench/testbench.sv]
// Self-checking bench for the transmit rail and rate configuration block
`timescale 1ns/100ps
module testbench;
  import line_cfg_pkg::*;
  logic clk, arst_n, config_source_strap, tx_amplitude_level, tx_all_ones_send;
  logic rx_equaliser_disable, local_loopback, remote_loopback, sonet_rate_select;
  logic euro_rate_select, transmitter_off, mgmt_chip_select_n, mgmt_serial_clock;
  logic serial_mgmt_in, register_clear_n, reg_wr_en, tx_binary_input_select;
  logic coder_disable_bit, rx_violation, first_rx_clock, serial_mgmt_out, serial_mgmt_out_oe;
  logic tx_line_clock, tx_positive_rail, tx_negative_rail, line_pulse_valid, mgmt_enabled;
  logic rail_single_mode, coder_bypass, signal_loss_mute_enable, second_rx_clock_invert;
  logic line_violation_flag, second_rx_clock, tx_amp_level_eff, tx_all_ones_eff;
  logic rx_eq_disable_eff, local_loop_eff, remote_loop_eff, tx_off_eff;
  logic [2:0]  reg_addr;
  logic [4:0]  reg_wr_data, reg_rd_data;
  line_pulse_s line_pulse;
  rate_cfg_s   rate_cfg;
  line_pulse_s seen_q[$];
  int          bad_count, check_count;
  logic [1:0]  exp_marks [6] = '{2'b10, 2'b01, 2'b10, 2'b01, 2'b01, 2'b10};
  logic [4:0]  wv [5] = '{5'h04, 5'h0c, 5'h00, 5'h08, 5'h0b};

  framer_model framer (.tx_line_clock(tx_line_clock), .tx_positive_rail(tx_positive_rail),
    .tx_negative_rail(tx_negative_rail));

  tx_rail_input_and_rate_config #(.FIFO_DEPTH(8)) dut (.clk(clk), .arst_n(arst_n),
    .config_source_strap(config_source_strap), .tx_amplitude_level(tx_amplitude_level),
    .tx_all_ones_send(tx_all_ones_send), .rx_equaliser_disable(rx_equaliser_disable),
    .local_loopback(local_loopback), .remote_loopback(remote_loopback),
    .sonet_rate_select(sonet_rate_select), .euro_rate_select(euro_rate_select),
    .transmitter_off(transmitter_off), .mgmt_chip_select_n(mgmt_chip_select_n),
    .mgmt_serial_clock(mgmt_serial_clock), .serial_mgmt_in(serial_mgmt_in),
    .register_clear_n(register_clear_n), .serial_mgmt_out(serial_mgmt_out),
    .serial_mgmt_out_oe(serial_mgmt_out_oe), .reg_wr_en(reg_wr_en), .reg_addr(reg_addr),
    .reg_wr_data(reg_wr_data), .reg_rd_data(reg_rd_data),
    .tx_binary_input_select(tx_binary_input_select), .coder_disable_bit(coder_disable_bit),
    .rx_violation(rx_violation), .first_rx_clock(first_rx_clock),
    .tx_line_clock(tx_line_clock), .tx_positive_rail(tx_positive_rail),
    .tx_negative_rail(tx_negative_rail), .line_pulse(line_pulse),
    .line_pulse_valid(line_pulse_valid), .rate_cfg(rate_cfg), .mgmt_enabled(mgmt_enabled),
    .rail_single_mode(rail_single_mode), .coder_bypass(coder_bypass),
    .signal_loss_mute_enable(signal_loss_mute_enable),
    .second_rx_clock_invert(second_rx_clock_invert),
    .line_violation_flag(line_violation_flag), .second_rx_clock(second_rx_clock),
    .tx_amp_level_eff(tx_amp_level_eff), .tx_all_ones_eff(tx_all_ones_eff),
    .rx_eq_disable_eff(rx_eq_disable_eff), .local_loop_eff(local_loop_eff),
    .remote_loop_eff(remote_loop_eff), .tx_off_eff(tx_off_eff));

  // 100 MHz system clock
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // Collect marks only; spaces carry no pulse
  always @(posedge clk)
    if (line_pulse_valid === 1'b1 && line_pulse !== 2'b00)
      seen_q.push_back(line_pulse);

  task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
    check_count++;
    if (got !== exp)
    begin
      bad_count++;
      $display("FAIL %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  task automatic give_verdict();
    $display("Checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : give_verdict

  // Strap is only latched after a reset, so each mode needs its own
  task automatic do_reset(input logic strap);
    arst_n = 1'b0;
    config_source_strap = strap;
    repeat (6) @(posedge clk);
    #1 arst_n = 1'b1;
    repeat (8) @(posedge clk);
    #1;
  endtask : do_reset

  // Rate and pin changes settle within about five cycles
  task automatic settle();
    repeat (8) @(posedge clk);
    #1;
  endtask : settle

  task automatic wr(input logic [2:0] a, input logic [4:0] d);
    reg_wr_en = 1'b1;
    reg_addr = a;
    reg_wr_data = d;
    @(posedge clk);
    #1 reg_wr_en = 1'b0;
    repeat (2) @(posedge clk);
    #1;
  endtask : wr

  // Watchdog against a hung run
  initial
  begin
    repeat (20000) @(posedge clk);
    bad_count++;
    give_verdict();
  end

  initial
  begin
    int i;
    line_rate_e er;
    {arst_n, config_source_strap, tx_amplitude_level, tx_all_ones_send} = 4'h0;
    {rx_equaliser_disable, local_loopback, remote_loopback, sonet_rate_select} = 4'h0;
    {euro_rate_select, transmitter_off, mgmt_serial_clock, serial_mgmt_in} = 4'h0;
    {reg_wr_en, tx_binary_input_select, coder_disable_bit, rx_violation} = 4'h0;
    {first_rx_clock, mgmt_chip_select_n, register_clear_n} = 3'h1;
    reg_addr = 3'h0;
    reg_wr_data = 5'h00;
    @(posedge clk);
    #1 do_reset(1'b0);
    // Pin mode: every E3 and rate pin combination
    for (i = 0; i < 4; i++)
    begin
      {euro_rate_select, sonet_rate_select} = i[1:0];
      settle();
      er = euro_rate_select ? RATE_E3 : (sonet_rate_select ? RATE_STS1 : RATE_DS3);
      check("rate", er, rate_cfg.rate);
      check("code", euro_rate_select ? CODE_HDB3 : CODE_B3ZS, rate_cfg.code);
      check("vco", er, rate_cfg.vco_centre_sel);
      check("los", er, rate_cfg.los_criteria_sel);
    end
    // Pin mode: pins live, serial pins in alternate roles, register writes refused
    {tx_amplitude_level, tx_all_ones_send, rx_equaliser_disable} = 3'h7;
    {local_loopback, remote_loopback, transmitter_off} = 3'h7;
    {euro_rate_select, sonet_rate_select} = 2'b00;
    {serial_mgmt_in, rx_violation, mgmt_serial_clock} = 3'h7;
    wr(3'h4, 5'h04);
    settle();
    check("pin eff", 8'h3f, {tx_amp_level_eff, tx_all_ones_eff, rx_eq_disable_eff,
      local_loop_eff, remote_loop_eff, tx_off_eff});
    check("alt", 8'h7, {signal_loss_mute_enable, serial_mgmt_out, serial_mgmt_out_oe});
    check("pin rd", 8'h00, {mgmt_enabled, reg_rd_data});
    check("pin rate", RATE_DS3, rate_cfg.rate);
    check("bypass", 8'h1, coder_bypass);
    // Dual-rail traffic through the bypassed coder, a both-high pair among it
    framer.send(16'h0099, 16'h006a, 8);
    for (i = 0; i < 60 && seen_q.size() < 6; i++)
      @(posedge clk);
    settle();
    check("mark count", 8'h6, seen_q.size());
    for (i = 0; i < 6 && i < seen_q.size(); i++)
      check("mark", exp_marks[i], seen_q[i]);
    // Register mode, ignored pins tied low by the board
    {tx_amplitude_level, tx_all_ones_send, rx_equaliser_disable} = 3'h0;
    {local_loopback, remote_loopback, transmitter_off, mgmt_serial_clock} = 4'h0;
    do_reset(1'b1);
    check("host", 8'h4, {mgmt_enabled, serial_mgmt_out_oe, line_violation_flag});
    check("cr reset", 8'h00, reg_rd_data);
    for (i = 0; i < 5; i++)
    begin
      wr(3'h4, wv[i]);
      er = wv[i][2] ? RATE_E3 : (wv[i][3] ? RATE_STS1 : RATE_DS3);
      check("cr rd", wv[i], reg_rd_data);
      check("cr rate", er, rate_cfg.rate);
      check("loops", wv[i][1:0], {local_loop_eff, remote_loop_eff});
    end
    wr(3'h3, 5'h1f);
    check("unmapped", 8'h00, reg_rd_data);
    reg_addr = 3'h4;
    #1 check("cr kept", 8'h0b, reg_rd_data);
    register_clear_n = 1'b0;
    @(posedge clk);
    #1 register_clear_n = 1'b1;
    settle();
    check("cleared", 8'h00, {rate_cfg.rate, reg_rd_data});
    // Single rail keeps the coder on even when its bit asks for bypass
    {tx_binary_input_select, coder_disable_bit} = 2'b11;
    settle();
    check("single", 8'h2, {rail_single_mode, coder_bypass});
    tx_binary_input_select = 1'b0;
    settle();
    check("reg bypass", CODE_BYPASS, rate_cfg.code);
    give_verdict();
  end
endmodule : testbench
